// file: pkg/clip_pkg.sv
// shared constants, sample carrier and state encoding of the iq peak clipper
// assumes 32-bit ahb-lite register access and 16-bit signed i/q samples
package clip_pkg;

	localparam int SAMPLE_W = 16;
	localparam int PCT_W = 7;

	// register byte offsets
	localparam logic [7:0] OFF_CTRL = 8'h00;
	localparam logic [7:0] OFF_PEAK = 8'h04;
	localparam logic [7:0] OFF_PCT = 8'h08;
	localparam logic [7:0] OFF_STATUS = 8'h0C;
	localparam logic [7:0] OFF_COUNT = 8'h10;
	localparam logic [7:0] OFF_LIMIT = 8'h14;

	// field positions
	localparam int CTRL_ENABLE_BIT = 0;
	localparam int CTRL_RECT_BIT = 1;
	localparam int CTRL_POST_BIT = 2;
	localparam int CTRL_CODED_BIT = 3;
	localparam int PCT_I_LSB = 0;
	localparam int PCT_Q_LSB = 8;
	localparam int LIMIT_Q_LSB = 16;
	localparam int STATUS_POST_BIT = 0;
	localparam int STATUS_BUSY_BIT = 1;
	localparam int STATUS_PASS_BIT = 2;

	// reset values
	localparam logic [3:0] CTRL_RST = 4'h0;
	localparam logic [15:0] PEAK_RST = 16'h7FFF;
	localparam logic [6:0] PCT_RST = 7'h64;
	localparam logic [31:0] COUNT_RST = 32'h0000_0000;

	// percentage arithmetic: full scale and 2^20/100 reciprocal
	localparam logic [6:0] PCT_FULL = 7'h64;
	localparam logic [15:0] RECIP_100 = 16'h28F6;
	localparam int RECIP_SHIFT = 20;

	// ahb-lite codes
	localparam logic [2:0] HSIZE_WORD = 3'h2;

	typedef struct packed {
		logic signed [15:0] i;
		logic signed [15:0] q;
	} iq_t;

	typedef enum logic [2:0] {
		ST_IDLE = 3'b000,
		ST_MAG = 3'b001,
		ST_DIV_I = 3'b011,
		ST_DIV_Q = 3'b010,
		ST_DONE = 3'b110
	} clip_state_t;

endpackage : clip_pkg

// file: hw/int_sqrt.sv
// iterative integer square root, one result bit per clock
// assumes start is a one-cycle pulse and only given while idle
`timescale 1ns/1ps
module int_sqrt #(
	parameter int QW = 16
) (
	input wire logic hclk,
	input wire logic hresetn,
	input wire logic start,
	input wire logic [2*QW-1:0] radicand,
	output logic done,
	output logic [QW-1:0] root
);
	localparam int CW = $clog2(QW);
	logic [2*QW-1:0] rad_q;
	logic [CW-1:0] idx_q;
	logic busy_q;
	logic [QW-1:0] trial;
	logic [2*QW-1:0] trial_sq;

	assign trial = root | (QW'(1) << idx_q);
	assign trial_sq = trial * trial;

	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			rad_q <= '0;
			idx_q <= '0;
			busy_q <= 1'b0;
			root <= '0;
			done <= 1'b0;
		end
		else
		begin
			done <= busy_q && (idx_q == '0);
			if (start)
			begin
				rad_q <= radicand;
				root <= '0;
				idx_q <= CW'(QW - 1);
				busy_q <= 1'b1;
			end
			else if (busy_q)
			begin
				if (trial_sq <= rad_q)
					root <= trial;
				if (idx_q == '0)
					busy_q <= 1'b0;
				else
					idx_q <= idx_q - 1'b1;
			end
		end
	end
endmodule : int_sqrt

// file: hw/int_divide.sv
// restoring unsigned divider, one quotient bit per clock
// assumes start only while idle and a non-zero divisor
`timescale 1ns/1ps
module int_divide #(
	parameter int NW = 32,
	parameter int DW = 16
) (
	input wire logic hclk,
	input wire logic hresetn,
	input wire logic start,
	input wire logic [NW-1:0] numer,
	input wire logic [DW-1:0] denom,
	output logic done,
	output logic [NW-1:0] quot
);
	localparam int CW = $clog2(NW);
	logic [DW-1:0] rem_q;
	logic [DW-1:0] den_q;
	logic [CW-1:0] cnt_q;
	logic busy_q;
	logic [DW:0] shifted;
	logic [DW:0] diff;

	assign shifted = {rem_q, quot[NW-1]};
	assign diff = shifted - {1'b0, den_q};

	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			rem_q <= '0;
			den_q <= '0;
			cnt_q <= '0;
			busy_q <= 1'b0;
			quot <= '0;
			done <= 1'b0;
		end
		else
		begin
			done <= busy_q && (cnt_q == '0);
			if (start)
			begin
				rem_q <= '0;
				den_q <= denom;
				quot <= numer;
				cnt_q <= CW'(NW - 1);
				busy_q <= 1'b1;
			end
			else if (busy_q)
			begin
				if (shifted >= {1'b0, den_q})
				begin
					rem_q <= diff[DW-1:0];
					quot <= {quot[NW-2:0], 1'b1};
				end
				else
				begin
					rem_q <= shifted[DW-1:0];
					quot <= {quot[NW-2:0], 1'b0};
				end
				if (cnt_q == '0)
					busy_q <= 1'b0;
				else
					cnt_q <= cnt_q - 1'b1;
			end
		end
	end
endmodule : int_divide

// file: hw/iq_peak_clipper.sv
// i/q peak clipper with ahb-lite registers and four valid/ready sample ports
// assumes one clock; the fir filter sits outside between fir_tx and fir_rx
//
// Summary of operation
// - envelope magnitude is the square root of I squared plus Q squared.
// - circular mode limits the complex sample by its vector magnitude.
// - circular mode uses one threshold for every phase angle.
// - rectangular mode limits |I| and |Q| each against its own threshold.
// - rectangular mode takes separate, possibly unequal I and Q settings.
// - each threshold is a percentage of the programmed greatest peak.
// - a 100 percent setting passes samples unchanged.
// - a lower percentage gives a lower, monotonically scaled limit.
// - the clipper sits before or after the fir filter by configuration.
// - position is selectable only in coded-channel formats, not dual player.
//
// The AHB-Lite interface to the registers and the register offsets were left to the implementer.
`timescale 1ns/1ps
module iq_peak_clipper (
	input wire logic hclk,
	input wire logic hresetn,
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic hreadyout,
	output logic hresp,
	output logic [31:0] hrdata,
	input wire logic src_valid,
	output logic src_ready,
	input wire clip_pkg::iq_t src_data,
	output logic fir_tx_valid,
	input wire logic fir_tx_ready,
	output clip_pkg::iq_t fir_tx_data,
	input wire logic fir_rx_valid,
	output logic fir_rx_ready,
	input wire clip_pkg::iq_t fir_rx_data,
	output logic dst_valid,
	input wire logic dst_ready,
	output clip_pkg::iq_t dst_data
);
	function automatic logic [15:0] abs16(input logic signed [15:0] v);
		abs16 = v[15] ? 16'(-v) : 16'(v);
	endfunction : abs16
	function automatic logic signed [15:0] signed16(input logic [15:0] m, input logic neg);
		logic [16:0] e;
		e = {1'b0, m};
		if (neg)
			signed16 = 16'(~e + 17'h0_0001);
		else if (m > 16'h7FFF)
			signed16 = 16'sh7FFF;
		else
			signed16 = m;
	endfunction : signed16
	function automatic logic [15:0] pct_limit(input logic [15:0] peak, input logic [6:0] pct);
		logic [39:0] prod;
		prod = 40'(peak) * 40'(pct) * 40'(clip_pkg::RECIP_100);
		if (pct >= clip_pkg::PCT_FULL)
			pct_limit = peak;
		else
			pct_limit = prod[clip_pkg::RECIP_SHIFT+15:clip_pkg::RECIP_SHIFT];
	endfunction : pct_limit
	function automatic logic signed [15:0] clamp16(input logic signed [15:0] v, input logic [15:0] lim,
		input logic [6:0] pct);
		if (pct >= clip_pkg::PCT_FULL || abs16(v) <= lim)
			clamp16 = v;
		else
			clamp16 = signed16(lim, v[15]);
	endfunction : clamp16

	logic ctrl_enable_q, ctrl_rect_q, ctrl_post_q, ctrl_coded_q;
	logic [15:0] peak_q, lim_i_q, lim_q_q;
	logic [6:0] pct_i_q, pct_q_q;
	logic [31:0] count_q, rd_d, sqrt_rad, div_numer, div_quot, sq_i, sq_q;
	logic [7:0] wr_addr_q;
	logic wr_pend_q, addr_phase, post_sel_q, post_eff, clip_event, pass_full_q;
	clip_pkg::clip_state_t state_q;
	clip_pkg::iq_t cur_q, res_q, pass_data_q, pass_in_data, core_in_data;
	logic pass_in_valid, pass_in_ready, pass_out_ready, core_in_valid, core_in_ready, core_out_ready, core_take;
	logic sqrt_start, sqrt_done, div_start, div_done;
	logic [15:0] sqrt_root, div_denom;

	// bus slave: always ready, always okay
	assign hreadyout = 1'b1;
	assign hresp = 1'b0;
	assign addr_phase = hsel && htrans[1] && hready;

	always_comb
	begin
		rd_d = 32'h0000_0000;
		case (haddr[7:0])
			clip_pkg::OFF_CTRL:
			begin
				rd_d[clip_pkg::CTRL_ENABLE_BIT] = ctrl_enable_q;
				rd_d[clip_pkg::CTRL_RECT_BIT] = ctrl_rect_q;
				rd_d[clip_pkg::CTRL_POST_BIT] = ctrl_post_q;
				rd_d[clip_pkg::CTRL_CODED_BIT] = ctrl_coded_q;
			end
			clip_pkg::OFF_PEAK: rd_d[15:0] = peak_q;
			clip_pkg::OFF_PCT:
			begin
				rd_d[clip_pkg::PCT_I_LSB +: clip_pkg::PCT_W] = pct_i_q;
				rd_d[clip_pkg::PCT_Q_LSB +: clip_pkg::PCT_W] = pct_q_q;
			end
			clip_pkg::OFF_STATUS:
			begin
				rd_d[clip_pkg::STATUS_POST_BIT] = post_sel_q;
				rd_d[clip_pkg::STATUS_BUSY_BIT] = (state_q != clip_pkg::ST_IDLE);
				rd_d[clip_pkg::STATUS_PASS_BIT] = pass_full_q;
			end
			clip_pkg::OFF_COUNT: rd_d = count_q;
			clip_pkg::OFF_LIMIT: rd_d = {lim_q_q, lim_i_q};
			default: rd_d = 32'h0000_0000;
		endcase
	end

	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			wr_pend_q <= 1'b0;
			wr_addr_q <= 8'h00;
			hrdata <= 32'h0000_0000;
		end
		else
		begin
			wr_pend_q <= addr_phase && hwrite && (hsize == clip_pkg::HSIZE_WORD);
			if (addr_phase)
				wr_addr_q <= haddr[7:0];
			if (addr_phase && !hwrite)
				hrdata <= rd_d;
		end
	end

	// configuration registers
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			{ctrl_coded_q, ctrl_post_q, ctrl_rect_q, ctrl_enable_q} <= clip_pkg::CTRL_RST;
			peak_q <= clip_pkg::PEAK_RST;
			pct_i_q <= clip_pkg::PCT_RST;
			pct_q_q <= clip_pkg::PCT_RST;
		end
		else if (wr_pend_q)
		begin
			case (wr_addr_q)
				clip_pkg::OFF_CTRL:
				begin
					ctrl_enable_q <= hwdata[clip_pkg::CTRL_ENABLE_BIT];
					ctrl_rect_q <= hwdata[clip_pkg::CTRL_RECT_BIT];
					ctrl_post_q <= hwdata[clip_pkg::CTRL_POST_BIT];
					ctrl_coded_q <= hwdata[clip_pkg::CTRL_CODED_BIT];
				end
				clip_pkg::OFF_PEAK: peak_q <= hwdata[15:0];
				clip_pkg::OFF_PCT:
				begin
					pct_i_q <= hwdata[clip_pkg::PCT_I_LSB +: clip_pkg::PCT_W];
					pct_q_q <= hwdata[clip_pkg::PCT_Q_LSB +: clip_pkg::PCT_W];
				end
				default: ;
			endcase
		end
	end

	// limits from peak reference and percentage
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			lim_i_q <= clip_pkg::PEAK_RST;
			lim_q_q <= clip_pkg::PEAK_RST;
		end
		else
		begin
			lim_i_q <= pct_limit(peak_q, pct_i_q);
			lim_q_q <= pct_limit(peak_q, pct_q_q);
		end
	end

	// clipped-sample counter; a write clears it, a clip in the same cycle leaves it at one
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
			count_q <= clip_pkg::COUNT_RST;
		else if (clip_event && wr_pend_q && wr_addr_q == clip_pkg::OFF_COUNT)
			count_q <= 32'h0000_0001;
		else if (wr_pend_q && wr_addr_q == clip_pkg::OFF_COUNT)
			count_q <= clip_pkg::COUNT_RST;
		else if (clip_event)
			count_q <= count_q + 32'h0000_0001;
	end

	// position choice, only taken when both paths are empty
	assign post_eff = ctrl_post_q && ctrl_coded_q;
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
			post_sel_q <= 1'b0;
		else if (state_q == clip_pkg::ST_IDLE && !pass_full_q)
			post_sel_q <= post_eff;
	end

	// stream routing around the external fir
	assign core_in_valid = post_sel_q ? fir_rx_valid : src_valid;
	assign core_in_data = post_sel_q ? fir_rx_data : src_data;
	assign core_out_ready = post_sel_q ? dst_ready : fir_tx_ready;
	assign pass_in_valid = post_sel_q ? src_valid : fir_rx_valid;
	assign pass_in_data = post_sel_q ? src_data : fir_rx_data;
	assign pass_out_ready = post_sel_q ? fir_tx_ready : dst_ready;
	assign core_in_ready = (state_q == clip_pkg::ST_IDLE);
	assign pass_in_ready = !pass_full_q || pass_out_ready;
	assign core_take = core_in_valid && core_in_ready;
	assign src_ready = post_sel_q ? pass_in_ready : core_in_ready;
	assign fir_rx_ready = post_sel_q ? core_in_ready : pass_in_ready;
	assign fir_tx_valid = post_sel_q ? pass_full_q : (state_q == clip_pkg::ST_DONE);
	assign fir_tx_data = post_sel_q ? pass_data_q : res_q;
	assign dst_valid = post_sel_q ? (state_q == clip_pkg::ST_DONE) : pass_full_q;
	assign dst_data = post_sel_q ? res_q : pass_data_q;

	// one-entry register stage for the unclipped path
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			pass_full_q <= 1'b0;
			pass_data_q <= '0;
		end
		else if (pass_in_ready)
		begin
			pass_full_q <= pass_in_valid;
			if (pass_in_valid)
				pass_data_q <= pass_in_data;
		end
	end

	// arithmetic helpers
	assign sq_i = 32'($signed(core_in_data.i) * $signed(core_in_data.i));
	assign sq_q = 32'($signed(core_in_data.q) * $signed(core_in_data.q));
	assign sqrt_rad = sq_i + sq_q;
	assign div_denom = sqrt_root;

	always_comb
	begin
		sqrt_start = 1'b0;
		div_start = 1'b0;
		div_numer = 32'h0000_0000;
		case (state_q)
			clip_pkg::ST_IDLE:
				sqrt_start = core_take && ctrl_enable_q && !ctrl_rect_q && (pct_i_q < clip_pkg::PCT_FULL);
			clip_pkg::ST_MAG:
			begin
				div_start = sqrt_done && (sqrt_root > lim_i_q);
				div_numer = 32'(abs16(cur_q.i)) * 32'(lim_i_q);
			end
			clip_pkg::ST_DIV_I:
			begin
				div_start = div_done;
				div_numer = 32'(abs16(cur_q.q)) * 32'(lim_i_q);
			end
			default: ;
		endcase
	end

	// clip engine
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			state_q <= clip_pkg::ST_IDLE;
			cur_q <= '0;
			res_q <= '0;
			clip_event <= 1'b0;
		end
		else
		begin
			clip_event <= 1'b0;
			case (state_q)
				clip_pkg::ST_IDLE:
				begin
					if (core_take)
					begin
						cur_q <= core_in_data;
						if (sqrt_start)
							state_q <= clip_pkg::ST_MAG;
						else if (ctrl_enable_q && ctrl_rect_q)
						begin
							res_q.i <= clamp16(core_in_data.i, lim_i_q, pct_i_q);
							res_q.q <= clamp16(core_in_data.q, lim_q_q, pct_q_q);
							clip_event <= (clamp16(core_in_data.i, lim_i_q, pct_i_q) != core_in_data.i) ||
								(clamp16(core_in_data.q, lim_q_q, pct_q_q) != core_in_data.q);
							state_q <= clip_pkg::ST_DONE;
						end
						else
						begin
							res_q <= core_in_data;
							state_q <= clip_pkg::ST_DONE;
						end
					end
				end
				clip_pkg::ST_MAG:
				begin
					if (sqrt_done)
					begin
						if (div_start)
							state_q <= clip_pkg::ST_DIV_I;
						else
						begin
							res_q <= cur_q;
							state_q <= clip_pkg::ST_DONE;
						end
					end
				end
				clip_pkg::ST_DIV_I:
				begin
					if (div_done)
					begin
						res_q.i <= signed16(div_quot[15:0], cur_q.i[15]);
						state_q <= clip_pkg::ST_DIV_Q;
					end
				end
				clip_pkg::ST_DIV_Q:
				begin
					if (div_done)
					begin
						res_q.q <= signed16(div_quot[15:0], cur_q.q[15]);
						clip_event <= 1'b1;
						state_q <= clip_pkg::ST_DONE;
					end
				end
				clip_pkg::ST_DONE:
				begin
					if (core_out_ready)
						state_q <= clip_pkg::ST_IDLE;
				end
				default: state_q <= clip_pkg::ST_IDLE;
			endcase
		end
	end
	int_sqrt #(
		.QW(16)
	) u_sqrt (
		.hclk(hclk),
		.hresetn(hresetn),
		.start(sqrt_start),
		.radicand(sqrt_rad),
		.done(sqrt_done),
		.root(sqrt_root)
	);
	int_divide #(
		.NW(32),
		.DW(16)
	) u_div (
		.hclk(hclk),
		.hresetn(hresetn),
		.start(div_start),
		.numer(div_numer),
		.denom(div_denom),
		.done(div_done),
		.quot(div_quot)
	);

endmodule : iq_peak_clipper

// file: testbench/clip_props.sv
// concurrent checks on the clipper's bus and sample stream ports
// assumes the single hclk domain; bound to the clipper at the foot
`timescale 1ns/1ps
module clip_props (
	input wire logic hclk,
	input wire logic hresetn,
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic hready,
	input wire logic hreadyout,
	input wire logic hresp,
	input wire logic [31:0] hrdata,
	input wire logic src_valid,
	input wire logic src_ready,
	input wire clip_pkg::iq_t src_data,
	input wire logic fir_tx_valid,
	input wire logic fir_tx_ready,
	input wire clip_pkg::iq_t fir_tx_data,
	input wire logic fir_rx_valid,
	input wire logic fir_rx_ready,
	input wire clip_pkg::iq_t fir_rx_data,
	input wire logic dst_valid,
	input wire logic dst_ready,
	input wire clip_pkg::iq_t dst_data
);
	clip_pkg::iq_t src_cap_q;
	clip_pkg::iq_t rx_cap_q;
	default clocking @(posedge hclk); endclocking
	default disable iff (!hresetn);
	function automatic logic [16:0] amag(input logic [15:0] x);
		return x[15] ? 17'h0_0000 - {1'b1, x} : {1'b0, x};
	endfunction : amag
	function automatic logic no_grow(input clip_pkg::iq_t o, input clip_pkg::iq_t c);
		return amag(o.i) <= amag(c.i) && amag(o.q) <= amag(c.q);
	endfunction : no_grow
	function automatic logic same_sign(input clip_pkg::iq_t o, input clip_pkg::iq_t c);
		return (o.i == 16'h0 || o.i[15] == c.i[15]) && (o.q == 16'h0 || o.q[15] == c.q[15]);
	endfunction : same_sign
	sequence s_rd_unmapped;
		hsel && htrans[1] && hready && !hwrite && haddr[7:2] > 6'h05;
	endsequence
	sequence s_tx_stall;
		fir_tx_valid && !fir_tx_ready;
	endsequence
	sequence s_dst_stall;
		dst_valid && !dst_ready;
	endsequence
	// last sample taken on each input stream
	always_ff @(posedge hclk or negedge hresetn)
		if (!hresetn)
			src_cap_q <= '0;
		else if (src_valid && src_ready)
			src_cap_q <= src_data;
	always_ff @(posedge hclk or negedge hresetn)
		if (!hresetn)
			rx_cap_q <= '0;
		else if (fir_rx_valid && fir_rx_ready)
			rx_cap_q <= fir_rx_data;
	chk_bus_okay: assert property (hreadyout && !hresp) else $error("bus response not ready okay");
	chk_unmapped_zero: assert property (s_rd_unmapped |=> hrdata == 32'h0000_0000)
		else $error("unmapped read not zero");
	chk_tx_hold: assert property (s_tx_stall |=> fir_tx_valid && $stable(fir_tx_data))
		else $error("fir output dropped while stalled");
	chk_dst_hold: assert property (s_dst_stall |=> dst_valid && $stable(dst_data))
		else $error("dst output dropped while stalled");
	chk_tx_bound: assert property (fir_tx_valid |-> no_grow(fir_tx_data, src_cap_q))
		else $error("fir output larger than input");
	chk_dst_bound: assert property (dst_valid |-> no_grow(dst_data, rx_cap_q))
		else $error("dst output larger than input");
	chk_tx_sign: assert property (fir_tx_valid |-> same_sign(fir_tx_data, src_cap_q))
		else $error("fir output sign flipped");
	chk_dst_sign: assert property (dst_valid |-> same_sign(dst_data, rx_cap_q))
		else $error("dst output sign flipped");
	chk_src_block: assert property (s_tx_stall |-> !src_ready)
		else $error("source taken while output held");
	chk_rx_block: assert property (s_dst_stall |-> !fir_rx_ready)
		else $error("fir return taken while output held");
endmodule : clip_props

bind iq_peak_clipper clip_props i_clip_props (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
	.htrans(htrans), .hwrite(hwrite), .hready(hready), .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
	.src_valid(src_valid), .src_ready(src_ready), .src_data(src_data), .fir_tx_valid(fir_tx_valid),
	.fir_tx_ready(fir_tx_ready), .fir_tx_data(fir_tx_data), .fir_rx_valid(fir_rx_valid),
	.fir_rx_ready(fir_rx_ready), .fir_rx_data(fir_rx_data), .dst_valid(dst_valid), .dst_ready(dst_ready),
	.dst_data(dst_data));

// file: testbench/fir_model.sv
// stand-in for the external fir filter: holds one sample, returns it unchanged
// assumes the clipper's fir streams and a bench-driven stall
`timescale 1ns/1ps
module fir_model (
	input wire logic hclk,
	input wire logic hresetn,
	input wire logic stall,
	input wire logic fir_tx_valid,
	output logic fir_tx_ready,
	input wire clip_pkg::iq_t fir_tx_data,
	output logic fir_rx_valid,
	input wire logic fir_rx_ready,
	output clip_pkg::iq_t fir_rx_data,
	output clip_pkg::iq_t last_tx
);
	logic full_q;
	clip_pkg::iq_t hold_q;
	assign fir_tx_ready = !full_q && !stall;
	assign fir_rx_valid = full_q;
	// released line shows the inverse of the last sample
	assign fir_rx_data = full_q ? hold_q : ~hold_q;
	assign last_tx = hold_q;
	always_ff @(posedge hclk or negedge hresetn)
		if (!hresetn)
		begin
			full_q <= 1'b0;
			hold_q <= '0;
		end
		else if (fir_tx_valid && fir_tx_ready)
		begin
			full_q <= 1'b1;
			hold_q <= fir_tx_data;
		end
		else if (fir_rx_valid && fir_rx_ready)
			full_q <= 1'b0;
endmodule : fir_model

// file: testbench/tb_top.sv
// self-checking bench for the iq peak clipper with a stand-in fir filter
// assumes clip_pkg, the clipper, fir_model and the bound checker compiled first
`timescale 1ns/1ps
module tb_top;
	logic hclk = 1'b0;
	logic hresetn = 1'b0;
	logic hsel = 1'b0;
	logic hwrite = 1'b0;
	logic [1:0] htrans = 2'h0;
	logic [31:0] haddr = 32'h0;
	logic [31:0] hwdata = 32'h0;
	logic [31:0] hrdata;
	logic hready, hreadyout, hresp, src_ready, fir_tx_valid, fir_tx_ready, fir_rx_valid, fir_rx_ready, dst_valid;
	logic src_valid = 1'b0;
	logic dst_ready = 1'b0;
	logic stall = 1'b0;
	clip_pkg::iq_t src_data = '0;
	clip_pkg::iq_t fir_tx_data, fir_rx_data, dst_data, last_tx;
	int error_cnt = 0;
	int total_checks = 0;
	assign hready = hreadyout;
	always #50 hclk = ~hclk;
	iq_peak_clipper i_iq_peak_clipper (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
		.hwrite(hwrite), .hsize(clip_pkg::HSIZE_WORD), .hwdata(hwdata), .hready(hready), .hreadyout(hreadyout),
		.hresp(hresp), .hrdata(hrdata), .src_valid(src_valid), .src_ready(src_ready), .src_data(src_data),
		.fir_tx_valid(fir_tx_valid), .fir_tx_ready(fir_tx_ready), .fir_tx_data(fir_tx_data),
		.fir_rx_valid(fir_rx_valid), .fir_rx_ready(fir_rx_ready), .fir_rx_data(fir_rx_data),
		.dst_valid(dst_valid), .dst_ready(dst_ready), .dst_data(dst_data));
	fir_model i_fir_model (.hclk(hclk), .hresetn(hresetn), .stall(stall), .fir_tx_valid(fir_tx_valid),
		.fir_tx_ready(fir_tx_ready), .fir_tx_data(fir_tx_data), .fir_rx_valid(fir_rx_valid),
		.fir_rx_ready(fir_rx_ready), .fir_rx_data(fir_rx_data), .last_tx(last_tx));
	task automatic test_done();
		if (error_cnt == 0 && total_checks > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask : test_done
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		total_checks++;
		if (seen !== exp)
		begin
			error_cnt++;
			$display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask : check
	task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d, output logic [31:0] rd);
		@(posedge hclk);
		hsel <= 1'b1;
		haddr <= {24'h00_0000, a};
		htrans <= 2'h2;
		hwrite <= wr;
		do @(posedge hclk); while (hready !== 1'b1);
		htrans <= 2'h0;
		hwdata <= d;
		do @(posedge hclk); while (hready !== 1'b1);
		rd = hrdata;
	endtask : bus
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		logic [31:0] x;
		bus(1'b1, a, d, x);
	endtask : wr
	task automatic rd(input logic [7:0] a, input logic [31:0] exp);
		logic [31:0] x;
		bus(1'b0, a, 32'h0, x);
		check(x, exp);
	endtask : rd
	// one sample in at the source, one out at dst after lag cycles of back-pressure
	task automatic xfer(input logic [31:0] v, input logic [31:0] exp, input int lag);
		logic [31:0] got;
		fork
			begin
				@(posedge hclk);
				src_data <= v;
				src_valid <= 1'b1;
				do @(negedge hclk); while (src_ready !== 1'b1);
				@(posedge hclk);
				src_valid <= 1'b0;
				src_data <= ~v;
			end
			begin
				repeat (lag + 1) @(posedge hclk);
				dst_ready <= 1'b1;
				do @(negedge hclk); while (dst_valid !== 1'b1);
				got = dst_data;
				@(posedge hclk);
				dst_ready <= 1'b0;
			end
		join
		check(got, exp);
	endtask : xfer
	task automatic t_reset_vals();
		rd(clip_pkg::OFF_CTRL, 32'h0000_0000);
		rd(clip_pkg::OFF_PEAK, 32'h0000_7FFF);
		rd(clip_pkg::OFF_PCT, 32'h0000_6464);
		rd(clip_pkg::OFF_LIMIT, 32'h7FFF_7FFF);
		rd(clip_pkg::OFF_STATUS, 32'h0000_0000);
		wr(8'h18, 32'hFFFF_FFFF);
		rd(8'h18, 32'h0000_0000);
		wr(clip_pkg::OFF_CTRL, 32'h0000_0001);
		xfer(32'h7000_9000, 32'h7000_9000, 3);
		rd(clip_pkg::OFF_COUNT, 32'h0000_0000);
	endtask : t_reset_vals
	task automatic t_circular();
		wr(clip_pkg::OFF_PEAK, 32'h0000_4000);
		wr(clip_pkg::OFF_PCT, 32'h0000_1E32);
		rd(clip_pkg::OFF_LIMIT, 32'h1333_2000);
		xfer(32'h0BB8_0FA0, 32'h0BB8_0FA0, 0);
		xfer(32'hE890_1F40, 32'hECCD_1999, 2);
		xfer(32'h1F40_E890, 32'h1999_ECCD, 0);
		rd(clip_pkg::OFF_COUNT, 32'h0000_0002);
	endtask : t_circular
	task automatic t_rect();
		wr(clip_pkg::OFF_CTRL, 32'h0000_0003);
		xfer(32'h2710_F448, 32'h2000_F448, 0);
		stall <= 1'b1;
		fork
			xfer(32'h0BB8_E890, 32'h0BB8_ECCD, 0);
			begin
				repeat (8) @(posedge hclk);
				stall <= 1'b0;
			end
		join
		rd(clip_pkg::OFF_COUNT, 32'h0000_0004);
		wr(clip_pkg::OFF_COUNT, 32'h0000_0000);
		rd(clip_pkg::OFF_COUNT, 32'h0000_0000);
		wr(clip_pkg::OFF_PCT, 32'h0000_1E4B);
		rd(clip_pkg::OFF_LIMIT, 32'h1333_3000);
		xfer(32'h3E80_0000, 32'h3000_0000, 1);
		check(last_tx, 32'h3000_0000);
	endtask : t_rect
	task automatic t_position();
		wr(clip_pkg::OFF_CTRL, 32'h0000_0007);
		repeat (2) @(posedge hclk);
		rd(clip_pkg::OFF_STATUS, 32'h0000_0000);
		xfer(32'h3E80_0000, 32'h3000_0000, 0);
		check(last_tx, 32'h3000_0000);
		wr(clip_pkg::OFF_CTRL, 32'h0000_000F);
		repeat (2) @(posedge hclk);
		rd(clip_pkg::OFF_STATUS, 32'h0000_0001);
		xfer(32'h3E80_0000, 32'h3000_0000, 4);
		check(last_tx, 32'h3E80_0000);
	endtask : t_position
	initial
	begin
		repeat (6) @(posedge hclk);
		hresetn <= 1'b1;
		t_reset_vals();
		t_circular();
		t_rect();
		t_position();
		test_done();
	end
	initial
	begin
		repeat (20000) @(posedge hclk);
		error_cnt++;
		test_done();
	end
endmodule : tb_top
